// ==== hw/capture_timer_pkg.sv ====
// Purpose: Shared constants and carriers for the dual input capture timer
// Assumes: 32-bit APB, byte addresses as printed, 11-bit timer
// Notes: Channel config layout repeats at bit 0 and bit 14
package capture_timer_pkg;

    // Register byte addresses
    localparam logic [31:0] CTRL_ADDR = 32'h50004000;
    localparam logic [31:0] CONFIG_ADDR = 32'h50004004;
    localparam logic [31:0] STATUS_ADDR = 32'h50004008;
    localparam logic [31:0] RESULT_ONE_ADDR = 32'h5000400c;
    localparam logic [31:0] RESULT_TWO_ADDR = 32'h50004010;
    localparam logic [31:0] CLEAR_ADDR = 32'h50004014;

    // Field positions
    localparam int CFG_ONE_LSB = 0;
    localparam int CFG_TWO_LSB = 14;
    localparam int CFG_WIDTH = 14;
    localparam int CTRL_WIDTH = 17;
    localparam int CLR_ONE_BIT = 1;
    localparam int CLR_TWO_BIT = 2;
    localparam int CLR_WRAP_BIT = 0;

    // Reset values
    localparam logic [27:0] CONFIG_RESET = 28'h0000000;
    localparam logic [16:0] CTRL_RESET = 17'h00000;
    localparam logic [10:0] COUNT_RESET = 11'h000;

    // Counts and pin ranges
    localparam logic [10:0] COUNT_MAX = 11'h7ff;
    localparam logic [3:0] PIN_SEL_FIRST = 4'h1;
    localparam logic [3:0] PIN_SEL_LAST = 4'hc;
    localparam int PIN_COUNT = 12;

    // One input channel's configuration field
    typedef struct packed {
        logic stamp_select;
        logic [5:0] period_count;
        logic irq_enable;
        logic count_mode;
        logic falling_edge;
        logic [3:0] pin_select;
    } input_cfg_t;

    // Timer control word
    typedef struct packed {
        logic timer_clock_gate;
        logic system_clock_select;
        logic free_run_wrap;
        logic timer_irq_enable;
        logic count_down;
        logic timer_enable;
        logic [10:0] reload_value;
    } timer_ctrl_t;

    // Result register layout
    typedef struct packed {
        logic [10:0] rtc_upper;
        logic [10:0] result_low;
    } result_t;

endpackage

// ==== hw/dual_input_capture_count_timer.sv ====
// Purpose: Two-input capture and period-count timer with APB registers
// Assumes: Pins asynchronous; low-power tick and RTC stamp synchronous to clk_in
// Notes: Zero-wait-free APB slave, answers one cycle after setup
// Notes: Clock enable low freezes all state and stalls the bus
// Contract
// - Stamp select picks counter value or RTC stamp for a capture.
// - Period field sets count window to field plus one input periods.
// - Irq enable gates the input's capture or window-done interrupt.
// - Mode bit zero captures, one counts.
// - Polarity bit zero rising edge, one falling edge.
// - Pin select 1..12 picks a port-0 pin; other values disable input.
// - Overrun flag sets when an event arrives while pending.
// - On overrun the first event's result is kept.
// - Pending flags stay set until cleared by writing one.
// - Status low bits return the current timer count.
// - Count mode result is timer ticks minus one over the window.
// - Capture with counter stamp stores the timer count in low bits.
// - Capture with RTC stamp splits it into low and upper halves.
// - Upper result half is zero in count mode.
// - Clear register bits clear pending and overrun; read as zero.
// - Timer ticks from low-power or system clock, gated by a bit.
// - Timer wraps between zero and reload, or maximum in free-run, flagging an event.
`timescale 1ns/10ps
module dual_input_capture_count_timer (
    // Clock, reset, enable
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic ce_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Port-0 pins and time sources
    input wire logic [11:0] port0_pins_in,
    input wire logic lp_clock_tick_in,
    input wire logic [21:0] rtc_stamp_in,
    // Interrupt
    output logic irq_out
);

    // Pin select decode, shared by both channels
    function automatic logic pin_used(input logic [3:0] sel);
        pin_used = (sel >= capture_timer_pkg::PIN_SEL_FIRST) &&
                   (sel <= capture_timer_pkg::PIN_SEL_LAST);
    endfunction

    // Pick the selected pin, zero when unused
    // Mux sits ahead of the synchroniser, so a select change can look like an edge
    function automatic logic pin_pick(input logic [11:0] pins, input logic [3:0] sel);
        logic [3:0] idx;
        idx = sel - capture_timer_pkg::PIN_SEL_FIRST;
        pin_pick = pin_used(sel) ? pins[idx] : 1'b0;
    endfunction

    // Result word with the unused top bits zero; both result reads share it
    function automatic logic [31:0] result_word(input capture_timer_pkg::result_t r);
        result_word = {10'h000, r};
    endfunction

    // Register state
    logic [27:0] config_ff;
    logic [16:0] ctrl_ff;
    logic [10:0] count_ff;
    logic wrap_pending_ff;
    logic irq_ff;
    logic [31:0] prdata_ff;
    logic loaded_ff;

    // Decoded views
    capture_timer_pkg::timer_ctrl_t ctrl;
    capture_timer_pkg::input_cfg_t cfg [2];
    capture_timer_pkg::result_t result [2];
    logic [1:0] pending;
    logic [1:0] overrun;
    logic [1:0] clear_req;

    assign ctrl = capture_timer_pkg::timer_ctrl_t'(ctrl_ff);
    assign cfg[0] = capture_timer_pkg::input_cfg_t'(
        config_ff[capture_timer_pkg::CFG_ONE_LSB +: capture_timer_pkg::CFG_WIDTH]);
    assign cfg[1] = capture_timer_pkg::input_cfg_t'(
        config_ff[capture_timer_pkg::CFG_TWO_LSB +: capture_timer_pkg::CFG_WIDTH]);

    // APB decode
    logic access;
    logic done;
    logic wr_done;
    logic hit_ctrl;
    logic hit_config;
    logic hit_status;
    logic hit_res_one;
    logic hit_res_two;
    logic hit_clear;
    logic mapped;
    logic [31:0] rd_word;
    logic [31:0] status_word;

    assign access = psel_in & penable_in;
    assign hit_ctrl = paddr_in == capture_timer_pkg::CTRL_ADDR;
    assign hit_config = paddr_in == capture_timer_pkg::CONFIG_ADDR;
    assign hit_status = paddr_in == capture_timer_pkg::STATUS_ADDR;
    assign hit_res_one = paddr_in == capture_timer_pkg::RESULT_ONE_ADDR;
    assign hit_res_two = paddr_in == capture_timer_pkg::RESULT_TWO_ADDR;
    assign hit_clear = paddr_in == capture_timer_pkg::CLEAR_ADDR;
    assign mapped = hit_ctrl | hit_config | hit_status | hit_res_one | hit_res_two | hit_clear;

    // Answer only once read data was latched; stalls while ce_in is low
    assign pready_out = access & loaded_ff & ce_in;
    // Read-only and clear registers take writes without an error
    assign pslverr_out = pready_out & ~mapped;
    assign done = pready_out;
    assign wr_done = done & pwrite_in & mapped;
    assign prdata_out = prdata_ff;

    // Flags sit above the live count
    // count in status
    assign status_word = {16'h0000, overrun[1], overrun[0], pending[1], pending[0],
                          wrap_pending_ff, count_ff};

    // Read mux; clear register reads as zero
    assign rd_word = hit_ctrl ? {15'h0000, ctrl_ff} :
                     hit_config ? {4'h0, config_ff} :
                     hit_status ? status_word :
                     hit_res_one ? result_word(result[0]) :
                     hit_res_two ? result_word(result[1]) :
                     32'h00000000;

    assign clear_req[0] = wr_done & hit_clear & pwdata_in[capture_timer_pkg::CLR_ONE_BIT];
    assign clear_req[1] = wr_done & hit_clear & pwdata_in[capture_timer_pkg::CLR_TWO_BIT];

    // Read data latched in the setup cycle, one cycle before pready
    // Latching early lets pready rise in the first access cycle
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            prdata_ff <= 32'h00000000;
            loaded_ff <= 1'b0;
        end
        else if (ce_in)
        begin
            if (done)
                loaded_ff <= 1'b0;
            else if (psel_in && !loaded_ff)
            begin
                prdata_ff <= rd_word;
                loaded_ff <= 1'b1;
            end
        end
    end

    // Writable registers
    // Writes land only at the completing edge, never in setup
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            ctrl_ff <= capture_timer_pkg::CTRL_RESET;
            config_ff <= capture_timer_pkg::CONFIG_RESET;
        end
        else if (wr_done)
        begin
            if (hit_ctrl)
                ctrl_ff <= pwdata_in[16:0];
            if (hit_config)
                config_ff <= pwdata_in[27:0];
        end
    end

    // Timer tick and wrap point
    logic tick;
    logic at_wrap;
    logic [10:0] wrap_point;
    logic [10:0] nxt_count;
    logic wrap_event;
    logic wrap_clear;

    // Low-power ticks come in as one-cycle strobes of this clock
    // clock source and gate
    assign tick = ce_in & ctrl.timer_clock_gate & ctrl.timer_enable &
                  (ctrl.system_clock_select | lp_clock_tick_in);
    assign wrap_point = ctrl.free_run_wrap ? capture_timer_pkg::COUNT_MAX : ctrl.reload_value;
    assign at_wrap = ctrl.count_down ? (count_ff == 11'h000) : (count_ff == wrap_point);
    assign wrap_event = tick & at_wrap;
    assign nxt_count = !at_wrap ? (ctrl.count_down ? count_ff - 11'h001 : count_ff + 11'h001) :
                       ctrl.count_down ? wrap_point : 11'h000;
    assign wrap_clear = wr_done & hit_clear & pwdata_in[capture_timer_pkg::CLR_WRAP_BIT];

    // Timer counter; held while the tick is absent
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            count_ff <= capture_timer_pkg::COUNT_RESET;
        else if (tick)
            count_ff <= nxt_count;
    end

    // Timer pending; a wrap in the clear cycle wins
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            wrap_pending_ff <= 1'b0;
        else if (ce_in)
            wrap_pending_ff <= wrap_event | (wrap_pending_ff & ~wrap_clear);
    end

    // Input channels
    for (genvar g = 0; g < 2; g++)
    begin : chan
        logic pin_raw;
        logic used;
        logic edge_ev;
        logic capture_ev;
        logic window_done;
        logic chan_event;
        logic load;
        logic armed_ff;
        logic [5:0] periods_ff;
        logic [10:0] cycles_ff;
        logic [10:0] window_ticks;
        logic pending_ff;
        logic overrun_ff;
        capture_timer_pkg::result_t result_ff;
        capture_timer_pkg::result_t nxt_result;

        assign used = pin_used(cfg[g].pin_select);
        assign pin_raw = pin_pick(port0_pins_in, cfg[g].pin_select);

        // Two flops so a slow pin edge makes one event only
        // synchronise then detect
        edge_sync u_sync (
            .clk_in(clk_in),
            .reset_n_in(reset_n_in),
            .ce_in(ce_in),
            .pin_in(pin_raw),
            .falling_in(cfg[g].falling_edge),
            .event_out(edge_ev)
        );

        // mode chooses capture or window count
        assign capture_ev = edge_ev & used & ~cfg[g].count_mode;
        // window closes after period field plus one periods
        assign window_done = edge_ev & used & cfg[g].count_mode & armed_ff &
                             (periods_ff == cfg[g].period_count);
        assign chan_event = capture_ev | window_done;

        // Late events must not overwrite a stamp software has not read
        // keep first result while pending
        assign load = chan_event & (~pending_ff | clear_req[g]);

        // Closing edge's own tick belongs to the window being measured
        assign window_ticks = cycles_ff + {10'h000, tick};

        // ticks minus one; upper half zero in count mode
        assign nxt_result = cfg[g].count_mode ? {11'h000, window_ticks - 11'h001} :
                            cfg[g].stamp_select ? rtc_stamp_in :
                            {11'h000, count_ff};

        // Window counter, restarts on the edge that closes a window
        // Tick count is 11 bits and wraps, so very long windows alias
        always_ff @(posedge clk_in or negedge reset_n_in)
        begin
            if (!reset_n_in)
            begin
                armed_ff <= 1'b0;
                periods_ff <= 6'h00;
                cycles_ff <= 11'h000;
            end
            else if (ce_in)
            begin
                if (!cfg[g].count_mode || !used)
                    armed_ff <= 1'b0;
                else if (edge_ev)
                    armed_ff <= 1'b1;
                if (edge_ev && (!armed_ff || window_done))
                begin
                    periods_ff <= 6'h00;
                    cycles_ff <= 11'h000;
                end
                else
                begin
                    if (edge_ev)
                        periods_ff <= periods_ff + 6'h01;
                    if (tick)
                        cycles_ff <= cycles_ff + 11'h001;
                end
            end
        end

        // Flags; a new event beats a clear in the same cycle
        // An event in the clear cycle starts a fresh pending without overrun
        always_ff @(posedge clk_in or negedge reset_n_in)
        begin
            if (!reset_n_in)
            begin
                pending_ff <= 1'b0;
                overrun_ff <= 1'b0;
                result_ff <= '0;
            end
            else if (ce_in)
            begin
                pending_ff <= chan_event | (pending_ff & ~clear_req[g]);
                overrun_ff <= (chan_event & pending_ff & ~clear_req[g]) |
                              (overrun_ff & ~clear_req[g]);
                if (load)
                    result_ff <= nxt_result;
            end
        end

        assign pending[g] = pending_ff;
        assign overrun[g] = overrun_ff;
        assign result[g] = result_ff;
    end

    // Level interrupt from enabled pending flags
    // Registered so decode glitches never reach the pin
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            irq_ff <= 1'b0;
        else if (ce_in)
            irq_ff <= (pending[0] & cfg[0].irq_enable) |
                      (pending[1] & cfg[1].irq_enable) |
                      (wrap_pending_ff & ctrl.timer_irq_enable);
    end

    assign irq_out = irq_ff;

endmodule

// ==== hw/edge_sync.sv ====
// Purpose: Bring one event input into the clock domain and flag its edge
// Assumes: Pin is asynchronous to clk_in
// Notes: First stage feeds only the second stage
`timescale 1ns/10ps
module edge_sync (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic ce_in,
    // Pin and polarity
    input wire logic pin_in,
    input wire logic falling_in,
    // Edge pulse
    output logic event_out
);

    logic meta_ff;
    logic stable_ff;
    logic prev_ff;

    // Two-stage synchroniser plus history for edge detect
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            meta_ff <= 1'b0;
            stable_ff <= 1'b0;
            prev_ff <= 1'b0;
        end
        else if (ce_in)
        begin
            meta_ff <= pin_in;
            stable_ff <= meta_ff;
            prev_ff <= stable_ff;
        end
    end

    // One pulse per edge of the chosen polarity
    assign event_out = ce_in & (falling_in ? (prev_ff & ~stable_ff) : (~prev_ff & stable_ff));

endmodule

// ==== test/capture_timer_monitor.sv ====
// Purpose: Port checks for the capture timer
// Assumes: Sees only the top module ports
// Notes: Shadows enable bits from config and control writes
`timescale 1ns/10ps
module capture_timer_monitor (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic ce_in,
    // APB
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    // Interrupt
    input wire logic irq_out
);
    logic [27:0] cfg_ff;
    logic ctrl_irq_ff;
    // Decode of completed transfers; the map is six aligned words
    wire wr_done = psel_in && penable_in && pready_out && pwrite_in;
    wire rd_done = psel_in && penable_in && pready_out && !pwrite_in;
    wire in_page = paddr_in[31:5] == 27'h2800200;
    wire mapped = in_page && paddr_in[4:0] <= 5'h14 && paddr_in[1:0] == 2'h0;
    wire any_en = cfg_ff[6] || cfg_ff[20] || ctrl_irq_ff;

    // Shadow updates on the same edge the write lands
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            cfg_ff <= '0;
            ctrl_irq_ff <= 1'b0;
        end
        else if (wr_done && paddr_in == capture_timer_pkg::CONFIG_ADDR)
            cfg_ff <= pwdata_in[27:0];
        else if (wr_done && paddr_in == capture_timer_pkg::CTRL_ADDR)
            ctrl_irq_ff <= pwdata_in[13];
    end

    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    a_ready_in_access: assert property (pready_out |-> psel_in && penable_in && ce_in)
        else $error("ready outside an access");
    a_ready_one_cycle: assert property
        (psel_in && !penable_in && ce_in ##1 penable_in && ce_in |-> pready_out)
        else $error("access not answered at once");
    a_err_only_ready: assert property (pslverr_out |-> pready_out)
        else $error("error without ready");
    a_unmapped_err: assert property (pready_out && !mapped |-> pslverr_out)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (pready_out && mapped |-> !pslverr_out)
        else $error("mapped access refused");
    a_clear_reads_zero: assert property (
        rd_done && paddr_in == capture_timer_pkg::CLEAR_ADDR |-> prdata_out == 32'h0)
        else $error("clear register reads nonzero");
    a_config_readback: assert property (
        rd_done && paddr_in == capture_timer_pkg::CONFIG_ADDR |-> prdata_out == {4'h0, cfg_ff})
        else $error("config readback differs");
    a_result_upper_zero: assert property (
        rd_done && (paddr_in == capture_timer_pkg::RESULT_ONE_ADDR ||
        paddr_in == capture_timer_pkg::RESULT_TWO_ADDR) |-> prdata_out[31:22] == 10'h0)
        else $error("result bits above stamp set");
    a_irq_masked: assert property (irq_out |-> any_en || $past(any_en))
        else $error("interrupt while all masked");

    // Main scenarios
    c_irq: cover property (irq_out);
    c_refused: cover property (pslverr_out);
    c_overrun: cover property (rd_done && paddr_in == capture_timer_pkg::STATUS_ADDR
        && prdata_out[15]);
endmodule

bind dual_input_capture_count_timer capture_timer_monitor i_mon (.clk_in, .reset_n_in,
    .ce_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
    .pready_out, .pslverr_out, .irq_out);

// ==== test/pin_model.sv ====
// Purpose: Port-0 pins seen by the capture timer
// Assumes: Caller sits just after a rising edge
// Notes: Every level is held at least three cycles
`timescale 1ns/10ps
module pin_model (
    // Clock
    input wire logic clk_in,
    // Pins
    output logic [11:0] pins_out
);
    initial pins_out = 12'h000;

    // Full pulse, period two times h
    task automatic pulse(input int idx, input int h);
        pins_out[idx] <= 1'b1;
        repeat (h) @(posedge clk_in);
        pins_out[idx] <= 1'b0;
        repeat (h) @(posedge clk_in);
    endtask

    // Single level change, held long enough to be seen
    task automatic drive(input int idx, input logic v);
        pins_out[idx] <= v;
        repeat (4) @(posedge clk_in);
    endtask
endmodule

// ==== test/tb_top.sv ====
// Purpose: Register level test of the capture timer
// Assumes: APB master, pins from the pin model
// Notes: Ticks and stamps driven by the bench
`timescale 1ns/10ps
module tb_top;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic lp_tick = 1'b0;
    logic ce = 1'b1;
    logic e;
    logic [31:0] paddr_in = 32'h0;
    logic [31:0] pwdata_in = 32'h0;
    logic [31:0] rd;
    logic [31:0] a;
    logic [21:0] rtc = 22'h0;
    logic [3:0] unused_sel [4] = '{4'h0, 4'hd, 4'he, 4'hf};
    logic [31:0] prdata_out;
    logic pready_out;
    logic pslverr_out;
    logic irq_out;
    logic [11:0] pins;
    int n_errors = 0;
    int n_tests = 0;

    always #2.5 clk_in = ~clk_in;

    pin_model i_pins (.clk_in(clk_in), .pins_out(pins));

    dual_input_capture_count_timer i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .ce_in(ce), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
        .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out), .port0_pins_in(pins),
        .lp_clock_tick_in(lp_tick), .rtc_stamp_in(rtc), .irq_out(irq_out));

    task automatic final_report;
        $display("Comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", name, exp, got);
            n_errors++;
        end
    endtask

    // One transfer; request held until ready is seen at an edge
    task automatic apb(input logic wr, input logic [31:0] ad, input logic [31:0] d);
        int i;
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= ad;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge clk_in);
            if (pready_out === 1'b1)
                break;
        end
        if (i == 20)
        begin
            n_errors++;
            final_report();
        end
        rd = prdata_out;
        e = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clk_in);
    endtask

    // Masked read compare
    task automatic rchk(input string n, input logic [31:0] ad, input logic [31:0] m,
        input logic [31:0] exp);
        apb(1'b0, ad, 32'h0);
        check(n, rd & m, exp);
    endtask

    initial
    begin
        repeat (12) @(posedge clk_in);
        reset_n_in <= 1'b1;
        @(posedge clk_in);
        // Reset values, then a refused access
        for (a = capture_timer_pkg::CTRL_ADDR; a <= capture_timer_pkg::CLEAR_ADDR; a += 4)
            rchk("reset", a, 32'hffffffff, 32'h0);
        apb(1'b0, 32'h50004018, 32'h0);
        check("refused err", {31'h0, e}, 32'h1);
        check("refused data", rd, 32'h0);
        apb(1'b1, capture_timer_pkg::CONFIG_ADDR, 32'hffffffff);
        rchk("config", capture_timer_pkg::CONFIG_ADDR, 32'hffffffff, 32'h0fffffff);
        apb(1'b1, capture_timer_pkg::CONFIG_ADDR, 32'h0);
        $display("Test registers done");
        // Five low-power ticks, then a counter capture on input one
        apb(1'b1, capture_timer_pkg::CTRL_ADDR, 32'h00010fff);
        repeat (5)
        begin
            lp_tick <= 1'b1;
            @(posedge clk_in);
            lp_tick <= 1'b0;
            @(posedge clk_in);
        end
        // Ticks while the enable is low must not count
        ce <= 1'b0;
        lp_tick <= 1'b1;
        repeat (3) @(posedge clk_in);
        lp_tick <= 1'b0;
        ce <= 1'b1;
        rchk("count", capture_timer_pkg::STATUS_ADDR, 32'h7ff, 32'h5);
        apb(1'b1, capture_timer_pkg::CONFIG_ADDR, 32'h41);
        i_pins.pulse(0, 4);
        repeat (6) @(posedge clk_in);
        rchk("pending", capture_timer_pkg::STATUS_ADDR, 32'hffff, 32'h1005);
        rchk("stamp", capture_timer_pkg::RESULT_ONE_ADDR, 32'hffffffff, 32'h5);
        check("irq", {31'h0, irq_out}, 32'h1);
        apb(1'b1, capture_timer_pkg::CLEAR_ADDR, 32'h2);
        rchk("cleared", capture_timer_pkg::STATUS_ADDR, 32'hffff, 32'h0005);
        check("irq", {31'h0, irq_out}, 32'h0);
        $display("Test capture done");
        // Falling edge, stamp from the clock, masked; polarity set while unselected
        apb(1'b1, capture_timer_pkg::CONFIG_ADDR, 32'h08040000);
        i_pins.drive(1, 1'b1);
        apb(1'b1, capture_timer_pkg::CONFIG_ADDR, 32'h08048000);
        rtc <= 22'h2a5c3;
        i_pins.drive(1, 1'b0);
        repeat (4) @(posedge clk_in);
        rchk("pend two", capture_timer_pkg::STATUS_ADDR, 32'hffff, 32'h2005);
        check("irq", {31'h0, irq_out}, 32'h0);
        i_pins.drive(1, 1'b1);
        rtc <= 22'h15a3c;
        i_pins.drive(1, 1'b0);
        repeat (4) @(posedge clk_in);
        rchk("overrun", capture_timer_pkg::STATUS_ADDR, 32'hffff, 32'ha005);
        rchk("kept", capture_timer_pkg::RESULT_TWO_ADDR, 32'hffffffff, 32'h2a5c3);
        apb(1'b1, capture_timer_pkg::CLEAR_ADDR, 32'h4);
        rchk("cleared", capture_timer_pkg::STATUS_ADDR, 32'hffff, 32'h0005);
        $display("Test overrun done");
        // Unused selects ignore the pins
        foreach (unused_sel[k])
        begin
            apb(1'b1, capture_timer_pkg::CONFIG_ADDR, {28'h0, unused_sel[k]});
            i_pins.pulse(0, 4);
            repeat (4) @(posedge clk_in);
            rchk("unused", capture_timer_pkg::STATUS_ADDR, 32'hf000, 32'h0);
        end
        $display("Test unused done");
        // Count mode over two periods of ten system clocks
        apb(1'b1, capture_timer_pkg::CTRL_ADDR, 32'h000188ff);
        apb(1'b1, capture_timer_pkg::CONFIG_ADDR, 32'ha1);
        repeat (3) i_pins.pulse(0, 5);
        repeat (6) @(posedge clk_in);
        rchk("window", capture_timer_pkg::RESULT_ONE_ADDR, 32'hffffffff, 32'h13);
        rchk("done", capture_timer_pkg::STATUS_ADDR, 32'hf000, 32'h1000);
        // Wrap flag at the reload point
        apb(1'b1, capture_timer_pkg::CLEAR_ADDR, 32'h1);
        rchk("wrap clr", capture_timer_pkg::STATUS_ADDR, 32'h800, 32'h0);
        repeat (300) @(posedge clk_in);
        rchk("wrap", capture_timer_pkg::STATUS_ADDR, 32'hf00, 32'h800);
        $display("Test count done");
        final_report();
    end
endmodule
